// File: rtl/analog_input_parameter_record.sv
/*
 * parameter-record receiver of an eight-channel analog input module:
 * takes record one from the controller, applies it, substitutes the
 * overflow code while applying, and keeps diagnostic flags.
 * assumes the record port and converter port share mclk; error pins
 * are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module analog_input_parameter_record #(
    parameter int unsigned APPLY_CYCLES = analog_input_pkg::APPLY_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // record write port
    input wire logic write_parameter_record,
    input wire logic [7:0] record_number_select,
    input wire logic rec_byte_valid,
    input wire logic [7:0] rec_byte,
    output logic busy,
    output logic rec_done,
    output logic [15:0] result_code,
    // converter
    input wire logic conv_valid,
    input wire logic [2:0] conv_channel,
    input wire logic [12:0] conv_value,
    input wire logic [7:0] wire_break_pin,
    input wire logic common_mode_pin,
    input wire logic supply_fail_pin,
    // measured values and configuration
    output logic [7:0][15:0] meas_value,
    output analog_input_pkg::pair_cfg_s [3:0] pair_cfg,
    output logic [7:0] interrupt_enable,
    output logic [15:0] ch0_upper_limit,
    output logic [15:0] ch0_lower_limit,
    output logic [15:0] ch2_upper_limit,
    output logic [15:0] ch2_lower_limit,
    // interrupts toward the controller
    output analog_input_pkg::diag_s diag,
    input wire logic diag_ack,
    output logic diag_irq,
    output logic proc_irq,
    input wire logic proc_ack
);

    localparam int CW = $clog2(APPLY_CYCLES + 1);
    localparam logic [CW-1:0] APPLY_LAST = CW'(APPLY_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= {supply_fail_pin, common_mode_pin, wire_break_pin};
            pin_s2 <= pin_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // record transfer sequencer
    analog_input_pkg::state_e state;
    logic req_q;
    logic req_edge;
    logic [3:0] idx;
    logic commit;
    logic [CW-1:0] apply_cnt;
    logic [7:0] shadow [analog_input_pkg::REC_BYTES];

    assign req_edge = write_parameter_record && !req_q;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= write_parameter_record;
        end
    end

    // busy from request to end of apply
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= analog_input_pkg::ST_IDLE;
            busy <= 1'b0;
            rec_done <= 1'b0;
            result_code <= analog_input_pkg::RES_OK;
            idx <= 4'h0;
            commit <= 1'b0;
            apply_cnt <= '0;
        end else begin
            rec_done <= 1'b0;
            commit <= 1'b0;
            case (state)
                analog_input_pkg::ST_IDLE: begin
                    if (req_edge) begin
                        if (record_number_select == analog_input_pkg::REC_NUM) begin
                            state <= analog_input_pkg::ST_RECV;
                            busy <= 1'b1;
                            idx <= 4'h0;
                        end else begin
                            rec_done <= 1'b1;
                            result_code <= analog_input_pkg::ERR_RECORD;
                        end
                    end
                end
                analog_input_pkg::ST_RECV: begin
                    if (rec_byte_valid) begin
                        idx <= idx + 4'h1;
                        if (idx == analog_input_pkg::REC_LAST) begin
                            state <= analog_input_pkg::ST_APPLY;
                            commit <= 1'b1;
                            apply_cnt <= '0;
                        end
                    end
                end
                analog_input_pkg::ST_APPLY: begin
                    apply_cnt <= apply_cnt + CW'(1);
                    if (apply_cnt == APPLY_LAST) begin
                        state <= analog_input_pkg::ST_IDLE;
                        busy <= 1'b0;
                        rec_done <= 1'b1;
                        result_code <= analog_input_pkg::RES_OK;
                    end
                end
                default: begin
                    state <= analog_input_pkg::ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (state == analog_input_pkg::ST_RECV && rec_byte_valid) begin
            shadow[idx] <= rec_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // active parameter set
    logic [7:0] supp_byte;
    logic [7:0] pair_mode [analog_input_pkg::PAIRS];

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            interrupt_enable <= 8'h00;
            supp_byte <= analog_input_pkg::DEF_SUPP;
            for (int p = 0; p < analog_input_pkg::PAIRS; p++) begin
                pair_mode[p] <= analog_input_pkg::DEF_MODE;
            end
            ch0_upper_limit <= 16'h0000;
            ch0_lower_limit <= 16'h0000;
            ch2_upper_limit <= 16'h0000;
            ch2_lower_limit <= 16'h0000;
        end else if (commit) begin
            // bit 6 diag enable, bit 7 process enable
            interrupt_enable <= shadow[analog_input_pkg::IDX_IRQ]
                & analog_input_pkg::RSV_MASK;
            supp_byte <= shadow[analog_input_pkg::IDX_SUPP];
            for (int p = 0; p < analog_input_pkg::PAIRS; p++) begin
                pair_mode[p] <= shadow[analog_input_pkg::IDX_MODE + 4'(p)];
            end
            ch0_upper_limit <= {shadow[analog_input_pkg::IDX_C0UP],
                shadow[analog_input_pkg::IDX_C0UP + 4'h1]};
            ch0_lower_limit <= {shadow[analog_input_pkg::IDX_C0LO],
                shadow[analog_input_pkg::IDX_C0LO + 4'h1]};
            ch2_upper_limit <= {shadow[analog_input_pkg::IDX_C2UP],
                shadow[analog_input_pkg::IDX_C2UP + 4'h1]};
            ch2_lower_limit <= {shadow[analog_input_pkg::IDX_C2LO],
                shadow[analog_input_pkg::IDX_C2LO + 4'h1]};
        end
    end

    generate
        for (genvar p = 0; p < analog_input_pkg::PAIRS; p++) begin : g_pair
            pair_mode_decode u_dec (
                .mclk(mclk),
                .rst_sync_n(rst_sync_n),
                .mode(pair_mode[p]),
                .supp(supp_byte[2*p +: 2]),
                .cfg(pair_cfg[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // measured values
    logic applying;
    assign applying = (state == analog_input_pkg::ST_APPLY);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meas_value <= '0;
        end else if (applying) begin
            for (int c = 0; c < analog_input_pkg::CHANNELS; c++) begin
                meas_value[c] <= analog_input_pkg::OVF_CODE;
            end
        end else if (conv_valid) begin
            // sign and twelve bits, low three bits zero
            meas_value[conv_channel] <= {conv_value, 3'b000};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // limit crossing and process interrupt
    logic [1:0] crossed;
    logic [15:0] lim_up [2];
    logic [15:0] lim_lo [2];

    assign lim_up[0] = ch0_upper_limit;
    assign lim_lo[0] = ch0_lower_limit;
    assign lim_up[1] = ch2_upper_limit;
    assign lim_lo[1] = ch2_lower_limit;

    generate
        for (genvar k = 0; k < 2; k++) begin : g_lim
            limit_compare u_cmp (
                .mclk(mclk),
                .rst_sync_n(rst_sync_n),
                .sample_valid(conv_valid && !applying && (conv_channel == 3'(2 * k))),
                .sample({conv_value, 3'b000}),
                .upper(lim_up[k]),
                .lower(lim_lo[k]),
                .crossed(crossed[k])
            );
        end
    endgenerate

    logic proc_event;
    assign proc_event = (|crossed) && interrupt_enable[analog_input_pkg::BIT_PROC_EN];

    // set wins over acknowledge
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            proc_irq <= 1'b0;
        end else begin
            proc_irq <= proc_event || (proc_irq && !proc_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // diagnostics
    analog_input_pkg::diag_s diag_set;
    logic [7:0] ch_hit;

    always_comb begin
        ch_hit = 8'h00;
        ch_hit[conv_channel] = conv_valid && !applying;
        diag_set = '0;
        diag_set.param_err = rec_done && (result_code != analog_input_pkg::RES_OK);
        diag_set.proc_lost = proc_event && proc_irq && !proc_ack;
        diag_set.wire_break = pin_s2[7:0];
        diag_set.common_mode = pin_s2[8];
        diag_set.supply_fail = pin_s2[9];
        if (conv_value == analog_input_pkg::CONV_POS_FS) begin
            diag_set.over = ch_hit;
        end
        if (conv_value == analog_input_pkg::CONV_NEG_FS) begin
            diag_set.under = ch_hit;
        end
    end

    // sticky flags, set wins over acknowledge
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            diag <= '0;
        end else begin
            diag <= diag_set | (diag_ack ? '0 : diag);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            diag_irq <= 1'b0;
        end else begin
            diag_irq <= interrupt_enable[analog_input_pkg::BIT_DIAG_EN] && (|diag);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_busy_on_request: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (state == analog_input_pkg::ST_IDLE && req_edge
            && record_number_select == analog_input_pkg::REC_NUM)
        |=> busy && !rec_done)
        else $error("busy not raised on request");

    a_wrong_record: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (state == analog_input_pkg::ST_IDLE && req_edge
            && record_number_select != analog_input_pkg::REC_NUM)
        |=> rec_done && !busy && result_code == analog_input_pkg::ERR_RECORD)
        else $error("wrong record not refused");

    a_record_length: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (state == analog_input_pkg::ST_RECV && rec_byte_valid
            && idx == analog_input_pkg::REC_LAST)
        |=> applying && commit ##1 interrupt_enable == ($past(shadow[0])
            & analog_input_pkg::RSV_MASK))
        else $error("record not closed at byte 13");

    a_apply_overflow: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        applying |=> meas_value[0] == analog_input_pkg::OVF_CODE
            && meas_value[7] == analog_input_pkg::OVF_CODE)
        else $error("overflow code missing while applying");

    a_busy_until_done: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        $fell(busy) |-> rec_done && result_code == analog_input_pkg::RES_OK
            && $past(applying))
        else $error("busy fell before apply finished");

    a_sample_format: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (conv_valid && !applying && conv_channel == 3'h3)
        |=> meas_value[3] == {$past(conv_value), 3'b000})
        else $error("measured value format wrong");

    a_reserved_zero: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        interrupt_enable[5:0] == 6'h00)
        else $error("reserved enable bits not zero");

    a_reset_default: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        $rose(rst_sync_n) |-> pair_mode[0] == analog_input_pkg::DEF_MODE
            && supp_byte == analog_input_pkg::DEF_SUPP)
        else $error("default mode missing after reset");

    a_param_error_flag: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (rec_done && result_code != analog_input_pkg::RES_OK) |=> diag.param_err)
        else $error("parameter error not flagged");

endmodule
`default_nettype wire

// File: rtl/analog_input_pkg.sv
/*
 * constants, record layout and carrier types of the analog input
 * parameter-record block.
 * assumes a single 100 MHz clock shared by all users of the package.
 */
// What this block does
// - byte 0 bit 6 diag, bit 7 process enable
// - byte 1 holds two suppression bits per pair
// - bytes 2-5 pair mode: range low, type high
// - bytes 6-13 hold channel 0/2 limits
// - record one carries exactly fourteen bytes 0-13
// - measured values read 7fffh while applying
// - busy stays high until the write finishes
// - result code zero on success, nonzero on error
// - after reset all channels use default mode
// - type 1101b range 0100b selects type S
// - eight channels, twelve bits plus sign
// - diagnostics flag listed error conditions
package analog_input_pkg;

    ////////////////////////////////////////////////////////////////////
    // record layout
    localparam logic [7:0] REC_NUM = 8'h01;
    localparam logic [3:0] REC_LAST = 4'hd;
    localparam int REC_BYTES = 14;
    localparam logic [3:0] IDX_IRQ = 4'h0;
    localparam logic [3:0] IDX_SUPP = 4'h1;
    localparam logic [3:0] IDX_MODE = 4'h2;
    localparam logic [3:0] IDX_C0UP = 4'h6;
    localparam logic [3:0] IDX_C0LO = 4'h8;
    localparam logic [3:0] IDX_C2UP = 4'ha;
    localparam logic [3:0] IDX_C2LO = 4'hc;
    localparam int BIT_DIAG_EN = 6;
    localparam int BIT_PROC_EN = 7;
    localparam logic [7:0] RSV_MASK = 8'hc0;
    localparam int PAIRS = 4;
    localparam int CHANNELS = 8;

    ////////////////////////////////////////////////////////////////////
    // codes and defaults
    localparam logic [3:0] TYPE_TC_INT_LIN = 4'hd;
    localparam logic [3:0] RANGE_TYPE_S = 4'h4;
    // plus/minus 10 v range code, value arbitrary
    localparam logic [7:0] DEF_MODE = 8'h00;
    // 60 ms integration time code, value arbitrary
    localparam logic [7:0] DEF_SUPP = 8'h00;
    localparam logic [15:0] OVF_CODE = 16'h7fff;
    localparam logic [15:0] RES_OK = 16'h0000;
    localparam logic [15:0] ERR_RECORD = 16'h80b0;
    localparam logic [12:0] CONV_POS_FS = 13'h0fff;
    localparam logic [12:0] CONV_NEG_FS = 13'h1000;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ = 100;
    localparam int APPLY_TIME_US = 2000;
    localparam int APPLY_CYCLES = APPLY_TIME_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_APPLY = 2'b10
    } state_e;

    typedef struct packed {
        logic [1:0] supp;
        logic [3:0] mtype;
        logic [3:0] range;
        logic thermo_s;
    } pair_cfg_s;

    typedef struct packed {
        logic param_err;
        logic proc_lost;
        logic common_mode;
        logic supply_fail;
        logic [7:0] wire_break;
        logic [7:0] over;
        logic [7:0] under;
    } diag_s;

endpackage

// File: rtl/limit_compare.sv
/*
 * compares a new measured value of one channel with its upper and
 * lower limit and gives a one-cycle crossing pulse.
 * assumes value and limits are signed 16-bit on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module limit_compare (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // sample in
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    input wire logic [15:0] upper,
    input wire logic [15:0] lower,
    // crossing out
    output logic crossed
);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            crossed <= 1'b0;
        end else begin
            crossed <= sample_valid && (($signed(sample) > $signed(upper))
                || ($signed(sample) < $signed(lower)));
        end
    end

endmodule
`default_nettype wire

// File: rtl/pair_mode_decode.sv
/*
 * decodes the mode byte and suppression bits of one channel pair
 * into a registered pair configuration.
 * assumes mode and supp come from registers on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pair_mode_decode (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // configuration in
    input wire logic [7:0] mode,
    input wire logic [1:0] supp,
    // decoded out
    output analog_input_pkg::pair_cfg_s cfg
);

    // range low nibble, type high nibble
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg <= '0;
        end else begin
            cfg.range <= mode[3:0];
            cfg.mtype <= mode[7:4];
            cfg.supp <= supp;
            cfg.thermo_s <= (mode[7:4] == analog_input_pkg::TYPE_TC_INT_LIN)
                && (mode[3:0] == analog_input_pkg::RANGE_TYPE_S);
        end
    end

    a_thermo_s_code: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (mode == {analog_input_pkg::TYPE_TC_INT_LIN, analog_input_pkg::RANGE_TYPE_S})
        |=> cfg.thermo_s)
        else $error("type s code not decoded");

endmodule
`default_nettype wire

// File: tb/analog_input_parameter_record_tb.sv
/*
 * self-checking bench of the parameter-record block.
 * assumes the controller model in the same folder.
 */
`timescale 1ns/100ps
`default_nettype none
module analog_input_parameter_record_tb;
    localparam logic [13:0][7:0] REC_A = {8'h00, 8'h80, 8'h78, 8'h56, 8'h34, 8'h12, 8'hff,
        8'h7f, 8'hd4, 8'hd4, 8'hd4, 8'hd4, 8'haa, 8'hff};
    localparam logic [13:0][7:0] REC_B = {8'h01, 8'hfe, 8'h02, 8'hfd, 8'h03, 8'hfc, 8'h04,
        8'hfb, 8'h76, 8'h54, 8'h32, 8'h10, 8'h1b, 8'h40};
    logic mclk, rst_n, go, slow, sent, busy, rec_done, conv_valid, common_mode_pin;
    logic supply_fail_pin;
    logic [7:0] wire_break_pin;
    logic wpr, rbv, diag_irq, proc_irq;
    logic [7:0] rec_num, rns, rbyte, interrupt_enable;
    logic [13:0][7:0] recd;
    logic [15:0] result_code, c0u, c0l, c2u, c2l;
    logic [2:0] conv_channel;
    logic [12:0] conv_value;
    logic [7:0][15:0] meas_value;
    analog_input_pkg::pair_cfg_s [3:0] pair_cfg;
    analog_input_pkg::pair_cfg_s exp_cfg;
    analog_input_pkg::diag_s diag;
    int fails, n_compared, i;
    int n_done = 0;

    analog_input_parameter_record #(.APPLY_CYCLES(20)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .write_parameter_record(wpr), .record_number_select(rns), .rec_byte_valid(rbv),
        .rec_byte(rbyte), .busy(busy), .rec_done(rec_done), .result_code(result_code),
        .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_value(conv_value),
        .wire_break_pin(wire_break_pin), .common_mode_pin(common_mode_pin),
        .supply_fail_pin(supply_fail_pin),
        .meas_value(meas_value), .pair_cfg(pair_cfg), .interrupt_enable(interrupt_enable),
        .ch0_upper_limit(c0u), .ch0_lower_limit(c0l), .ch2_upper_limit(c2u),
        .ch2_lower_limit(c2l), .diag(diag), .diag_ack(1'b0), .diag_irq(diag_irq),
        .proc_irq(proc_irq), .proc_ack(1'b0));

    controller_model ctrl_u (.mclk(mclk), .go(go), .rec_num(rec_num), .rec(recd),
        .slow(slow), .sent(sent), .busy(busy), .write_parameter_record(wpr),
        .record_number_select(rns), .rec_byte_valid(rbv), .rec_byte(rbyte));

    ////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // waits at falling edges for a level, bounded
    task automatic wait_hi(ref logic s, input int lim);
        int k;
        for (k = 0; k < lim && s !== 1'b1; k++) begin
            @(negedge mclk);
        end
        if (s !== 1'b1) begin
            fails++;
            summarize();
        end
    endtask

    // counts completion pulses, which stand for one cycle only
    always @(posedge mclk) begin
        if (rec_done === 1'b1) begin
            n_done <= n_done + 1;
        end
    end

    // waits at falling edges for a number of completions, bounded
    task automatic wait_done(input int target, input int lim);
        int k;
        for (k = 0; k < lim && n_done < target; k++) begin
            @(negedge mclk);
        end
        if (n_done < target) begin
            fails++;
            summarize();
        end
    endtask

    task automatic send(input logic [7:0] num, input logic [13:0][7:0] r, input logic s);
        @(posedge mclk);
        go <= 1'b1;
        rec_num <= num;
        recd <= r;
        slow <= s;
        @(posedge mclk);
        go <= 1'b0;
        wait_hi(sent, 100);
    endtask

    task automatic conv(input logic [2:0] ch, input logic [12:0] v);
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_channel <= ch;
        conv_value <= v;
        @(posedge mclk);
        conv_valid <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic write_ok(input logic [13:0][7:0] r, input logic s);
        int base;
        base = n_done;
        send(analog_input_pkg::REC_NUM, r, s);
        chk({15'h0, busy}, 16'h0001);
        @(negedge mclk);
        @(negedge mclk);
        for (i = 0; i < 8; i++) begin
            chk(meas_value[i], analog_input_pkg::OVF_CODE);
        end
        wait_done(base + 1, 60);
        chk(result_code, analog_input_pkg::RES_OK);
        @(negedge mclk);
        chk({15'h0, busy}, 16'h0000);
        chk(16'(n_done - base), 16'h0001);
        chk({8'h0, interrupt_enable}, {8'h0, r[0] & 8'hc0});
        chk({8'h0, interrupt_enable}, {8'h0, r[0][7:6], 6'h00});
        for (i = 0; i < 4; i++) begin
            exp_cfg.supp = r[1][2 * i +: 2];
            exp_cfg.mtype = r[2 + i][7:4];
            exp_cfg.range = r[2 + i][3:0];
            exp_cfg.thermo_s = (r[2 + i] == 8'hd4);
            chk({5'h0, pair_cfg[i]}, {5'h0, exp_cfg});
        end
        chk(c0u, {r[6], r[7]});
        chk(c0l, {r[8], r[9]});
        chk(c2u, {r[10], r[11]});
        chk(c2l, {r[12], r[13]});
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        fails = 0;
        n_compared = 0;
        rst_n = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        rec_num = 8'h00;
        recd = '0;
        conv_valid = 1'b0;
        conv_channel = 3'h0;
        conv_value = 13'h0000;
        common_mode_pin = 1'b0;
        supply_fail_pin = 1'b0;
        wire_break_pin = 8'h00;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(negedge mclk);
        exp_cfg = '{analog_input_pkg::DEF_SUPP[1:0], analog_input_pkg::DEF_MODE[7:4],
            analog_input_pkg::DEF_MODE[3:0], 1'b0};
        for (i = 0; i < 4; i++) begin
            chk({5'h0, pair_cfg[i]}, {5'h0, exp_cfg});
        end
        conv(3'h3, 13'h0abc);
        chk(meas_value[3], {13'h0abc, 3'h0});
        conv(3'h5, analog_input_pkg::CONV_POS_FS);
        chk({15'h0, diag.over[5]}, 16'h0001);
        @(posedge mclk);
        common_mode_pin <= 1'b1;
        supply_fail_pin <= 1'b1;
        wire_break_pin <= 8'h04;
        repeat (6) @(negedge mclk);
        chk({15'h0, diag.common_mode}, 16'h0001);
        chk({15'h0, diag.supply_fail}, 16'h0001);
        chk({8'h0, diag.wire_break}, 16'h0004);
        // wrong record number is refused with an error code
        i = n_done;
        send(8'h02, REC_A, 1'b0);
        wait_done(i + 1, 10);
        chk({15'h0, result_code != 16'h0000}, 16'h0001);
        chk({15'h0, busy}, 16'h0000);
        chk({15'h0, diag.param_err}, 16'h0001);
        write_ok(REC_A, 1'b0);
        // channel 0 below its lower limit with both enables set
        conv(3'h0, 13'h0000);
        @(negedge mclk);
        chk({15'h0, proc_irq}, 16'h0001);
        chk({15'h0, diag_irq}, 16'h0001);
        write_ok(REC_B, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire

// File: tb/controller_model.sv
/*
 * behavioural model of the controlling cpu: sends one parameter record
 * per go pulse, back to back or with idle cycles between bytes.
 * assumes mclk of the block and that busy comes from the block.
 */
`timescale 1ns/100ps
`default_nettype none
module controller_model (
    // clock
    input wire logic mclk,
    // control from bench
    input wire logic go,
    input wire logic [7:0] rec_num,
    input wire logic [13:0][7:0] rec,
    input wire logic slow,
    output logic sent,
    // record port
    input wire logic busy,
    output logic write_parameter_record,
    output logic [7:0] record_number_select,
    output logic rec_byte_valid,
    output logic [7:0] rec_byte
);
    int n;
    initial begin
        sent = 1'b0;
        write_parameter_record = 1'b0;
        record_number_select = 8'h00;
        rec_byte_valid = 1'b0;
        rec_byte = 8'h5a;
        forever begin
            @(posedge mclk);
            if (go) begin
                // request held as a level until the record is out
                write_parameter_record <= 1'b1;
                record_number_select <= rec_num;
                @(posedge mclk);
                for (n = 0; n < 4 && busy !== 1'b1; n++) begin
                    @(posedge mclk);
                end
                for (n = 0; n < 14 && busy === 1'b1; n++) begin
                    rec_byte_valid <= 1'b1;
                    rec_byte <= rec[n];
                    @(posedge mclk);
                    if (slow) begin
                        rec_byte_valid <= 1'b0;
                        rec_byte <= ~rec[n];
                        @(posedge mclk);
                    end
                end
                rec_byte_valid <= 1'b0;
                rec_byte <= ~rec_byte;
                write_parameter_record <= 1'b0;
                sent <= 1'b1;
                @(posedge mclk);
                sent <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
